// >>> imu_output_data_registers.sv
// Output data register set: acceleration, temperature, time stamp, counter, delta angle.
//
// Notes on behaviour
// - Each accel axis has a read-only low word of extra resolution bits.
// - Accel high word is twos complement, 2.45 mm/s2 per count.
// - High and low accel words form one 32-bit value, high word on top.
// - Temperature is twos complement, 0.1 C per count, zero is 0x0000.
// - Time stamp counts 49.0 us steps (490 clock cycles) since the last sync pulse.
// - Time stamp runs only when misc control bits [3:2] select scaled sync.
// - Each update's stamp belongs to its last sample, relative to sync edge.
// - Counter starts at zero after reset and counts each data update.
// - Counter wraps from 0xFFFF to 0x0000 and keeps counting.
// - Counter is a 16-bit read-only register.
// - Delta angle is a trapezoidal sum of gyro rate over the window.
// - Each window sums decimation setting plus one samples.
// - Internal sample rate is nominally 2000 samples per second.
// - Each delta angle axis is a 32-bit value in two 16-bit registers.
// - Delta angle full scale is 360, 720 or 2160 degrees by variant.
// - Delta angle high word is twos complement, range over 2^15 per count.
`timescale 1ns/1ns
module imu_output_data_registers
    import imu_out_pkg::*;
#(
    parameter int unsigned VARIANT = 0
) (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        sampleValid,
    input  wire sample_t     sample,
    input  wire logic        syncPin,
    input  wire logic [6:0]  addr,
    input  wire logic [15:0] wrData,
    input  wire logic        wrEn,
    input  wire logic        rdEn,
    output logic      [15:0] rdData,
    output logic             dataReady
);

    // ------------------------------------------------------------------
    // Reset release and sync pin synchroniser
    // ------------------------------------------------------------------
    logic rstMeta;
    logic rstN;
    logic syncMeta;
    logic syncSafe;
    logic syncLast;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rstMeta <= 1'b0;
            rstN    <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstN    <= rstMeta;
        end
    end

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            syncMeta <= 1'b0;
            syncSafe <= 1'b0;
            syncLast <= 1'b0;
        end else begin
            syncMeta <= syncPin;
            syncSafe <= syncMeta;
            syncLast <= syncSafe;
        end
    end

    // ------------------------------------------------------------------
    // Control registers and decode
    // ------------------------------------------------------------------
    logic [15:0] miscControl;
    logic [15:0] decRate;
    logic [15:0] decCnt;
    logic [8:0]  stepCnt;
    logic [15:0] stampCnt;
    logic [15:0] updCount;

    wire logic       syncEdge  = syncSafe & ~syncLast;
    wire logic       scaled    = miscControl[SYNC_MODE_LSB +: 2] == SYNC_MODE_SCALED;
    wire logic       softReset = wrEn && addr == COMMAND_OFS && wrData[CMD_RESET_BIT];
    wire logic       lastSample = sampleValid && decCnt >= decRate;
    wire logic       loadNow   = lastSample && !softReset;
    wire logic       stepEnd   = stepCnt == 9'(STAMP_STEP_CYC - 1);
    wire logic [15:0] angleRange = (VARIANT == 2) ? RANGE_DEG_2 :
                                   (VARIANT == 1) ? RANGE_DEG_1 : RANGE_DEG_0;

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            miscControl <= MISC_CONTROL_RST;
            decRate     <= DEC_RATE_RST;
        end else if (wrEn && addr == MISC_CONTROL_OFS) begin
            miscControl <= wrData;
        end else if (wrEn && addr == DEC_RATE_OFS) begin
            decRate <= wrData;
        end
    end

    // ------------------------------------------------------------------
    // Time stamp since the last sync edge
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            stepCnt  <= 9'h000;
            stampCnt <= 16'h0000;
        end else if (!scaled || syncEdge) begin
            stepCnt  <= 9'h000;
            stampCnt <= 16'h0000;
        end else if (stepEnd) begin
            stepCnt  <= 9'h000;
            stampCnt <= stampCnt + 16'h0001;
        end else begin
            stepCnt <= stepCnt + 9'h001;
        end
    end

    // ------------------------------------------------------------------
    // Decimation window and trapezoidal delta angle
    // ------------------------------------------------------------------
    logic [2:0][15:0] gyroPrev;
    logic [2:0][31:0] deltaAcc;
    logic [2:0][31:0] deltaSum;

    // Each step adds the current and the previous rate sample; the 1/(2*fs)
    // factor and the gyro scale are folded into the output LSB weight.
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            deltaSum[i] = deltaAcc[i]
                        + {{16{sample.gyro[i][15]}}, sample.gyro[i]}
                        + {{16{gyroPrev[i][15]}}, gyroPrev[i]};
        end
    end

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            decCnt   <= 16'h0000;
            gyroPrev <= '0;
            deltaAcc <= '0;
        end else if (softReset) begin
            decCnt   <= 16'h0000;
            gyroPrev <= '0;
            deltaAcc <= '0;
        end else if (sampleValid) begin
            gyroPrev <= sample.gyro;
            decCnt   <= lastSample ? 16'h0000 : decCnt + 16'h0001;
            deltaAcc <= lastSample ? '0 : deltaSum;
        end
    end

    // ------------------------------------------------------------------
    // Output bank, loaded together at the end of each window
    // ------------------------------------------------------------------
    logic [2:0][31:0] accelOut;
    logic [2:0][31:0] deltaOut;
    logic [15:0]      tempOut;
    logic [15:0]      stampOut;

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            accelOut  <= '0;
            deltaOut  <= '0;
            tempOut   <= 16'h0000;
            stampOut  <= 16'h0000;
            updCount  <= COUNT_RST;
            dataReady <= 1'b0;
        end else if (softReset) begin
            updCount  <= COUNT_RST;
            dataReady <= 1'b0;
        end else begin
            dataReady <= loadNow;
            if (loadNow) begin
                accelOut <= sample.accel;
                deltaOut <= deltaSum;
                tempOut  <= sample.temp;
                stampOut <= stampCnt;
                updCount <= updCount + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read port, data one cycle after the strobe
    // ------------------------------------------------------------------
    logic [15:0] next_rdData;

    always_comb begin
        next_rdData = 16'h0000;
        if (addr == ACCEL_X_LOW_OFS) begin
            next_rdData = accelOut[0][15:0];
        end else if (addr == ACCEL_X_HIGH_OFS) begin
            next_rdData = accelOut[0][31:16];
        end else if (addr == ACCEL_Y_LOW_OFS) begin
            next_rdData = accelOut[1][15:0];
        end else if (addr == ACCEL_Y_HIGH_OFS) begin
            next_rdData = accelOut[1][31:16];
        end else if (addr == ACCEL_Z_LOW_OFS) begin
            next_rdData = accelOut[2][15:0];
        end else if (addr == ACCEL_Z_HIGH_OFS) begin
            next_rdData = accelOut[2][31:16];
        end else if (addr == TEMP_OFS) begin
            next_rdData = tempOut;
        end else if (addr == STAMP_OFS) begin
            next_rdData = stampOut;
        end else if (addr == UPD_COUNT_OFS) begin
            next_rdData = updCount;
        end else if (addr == DELTA_X_LOW_OFS) begin
            next_rdData = deltaOut[0][15:0];
        end else if (addr == DELTA_X_HIGH_OFS) begin
            next_rdData = deltaOut[0][31:16];
        end else if (addr == DELTA_Y_LOW_OFS) begin
            next_rdData = deltaOut[1][15:0];
        end else if (addr == DELTA_Y_HIGH_OFS) begin
            next_rdData = deltaOut[1][31:16];
        end else if (addr == DELTA_Z_LOW_OFS) begin
            next_rdData = deltaOut[2][15:0];
        end else if (addr == DELTA_Z_HIGH_OFS) begin
            next_rdData = deltaOut[2][31:16];
        end else if (addr == MISC_CONTROL_OFS) begin
            next_rdData = miscControl;
        end else if (addr == DEC_RATE_OFS) begin
            next_rdData = decRate;
        end else if (addr == ANGLE_RANGE_OFS) begin
            next_rdData = angleRange;
        end
    end

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            rdData <= 16'h0000;
        end else begin
            rdData <= rdEn ? next_rdData : 16'h0000;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence seqUpdate;
        loadNow;
    endsequence

    sequence seqStampStep;
        scaled && !syncEdge && stepEnd;
    endsequence

    AST_COUNT_STEP: assert property (@(posedge clk_sys) disable iff (!rstN)
        seqUpdate |=> updCount == 16'($past(updCount) + 16'h0001))
        else $error("update counter did not advance by one");

    AST_COUNT_RESET: assert property (@(posedge clk_sys) disable iff (!rstN)
        softReset |=> updCount == COUNT_RST && !dataReady)
        else $error("update counter not cleared by reset command");

    AST_COUNT_HOLD: assert property (@(posedge clk_sys) disable iff (!rstN)
        !loadNow && !softReset |=> $stable(updCount) && $stable(accelOut) && $stable(stampOut))
        else $error("outputs changed without a data update");

    AST_ACCEL_LOAD: assert property (@(posedge clk_sys) disable iff (!rstN)
        seqUpdate |=> accelOut == $past(sample.accel) && tempOut == $past(sample.temp))
        else $error("accel or temperature not loaded with the update");

    AST_STAMP_CLEAR: assert property (@(posedge clk_sys) disable iff (!rstN)
        scaled && syncEdge |=> stampCnt == 16'h0000 && stepCnt == 9'h000)
        else $error("time stamp not cleared by sync edge");

    AST_STAMP_STEP: assert property (@(posedge clk_sys) disable iff (!rstN)
        seqStampStep |=> stampCnt == 16'($past(stampCnt) + 16'h0001))
        else $error("time stamp did not step");

    AST_STAMP_OFF: assert property (@(posedge clk_sys) disable iff (!rstN)
        !scaled |=> stampCnt == 16'h0000)
        else $error("time stamp ran outside scaled sync mode");

    AST_STAMP_LOAD: assert property (@(posedge clk_sys) disable iff (!rstN)
        seqUpdate |=> stampOut == $past(stampCnt) ##0 dataReady)
        else $error("stamp of update not taken from last sample");

    AST_WINDOW: assert property (@(posedge clk_sys) disable iff (!rstN)
        sampleValid && !softReset && decCnt < decRate |=> decCnt == 16'($past(decCnt) + 16'h0001))
        else $error("decimation window count wrong");

    AST_DELTA_LOAD: assert property (@(posedge clk_sys) disable iff (!rstN)
        seqUpdate |=> deltaOut == $past(deltaSum) && deltaAcc == '0)
        else $error("delta angle not loaded at window end");

    AST_READ_COUNT: assert property (@(posedge clk_sys) disable iff (!rstN)
        rdEn && addr == UPD_COUNT_OFS |=> rdData == $past(updCount))
        else $error("counter read returned wrong value");

endmodule // imu_output_data_registers

// >>> imu_out_pkg.sv
// Constants and types shared by the output data register block.
package imu_out_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [6:0] ACCEL_X_LOW_OFS   = 7'h10;
    localparam logic [6:0] ACCEL_X_HIGH_OFS  = 7'h12;
    localparam logic [6:0] ACCEL_Y_LOW_OFS   = 7'h14;
    localparam logic [6:0] ACCEL_Y_HIGH_OFS  = 7'h16;
    localparam logic [6:0] ACCEL_Z_LOW_OFS   = 7'h18;
    localparam logic [6:0] ACCEL_Z_HIGH_OFS  = 7'h1A;
    localparam logic [6:0] TEMP_OFS          = 7'h1C;
    localparam logic [6:0] STAMP_OFS         = 7'h1E;
    localparam logic [6:0] UPD_COUNT_OFS     = 7'h22;
    localparam logic [6:0] DELTA_X_LOW_OFS   = 7'h24;
    localparam logic [6:0] DELTA_X_HIGH_OFS  = 7'h26;
    localparam logic [6:0] DELTA_Y_LOW_OFS   = 7'h28;
    localparam logic [6:0] DELTA_Y_HIGH_OFS  = 7'h2A;
    localparam logic [6:0] DELTA_Z_LOW_OFS   = 7'h2C;
    localparam logic [6:0] DELTA_Z_HIGH_OFS  = 7'h2E;
    localparam logic [6:0] MISC_CONTROL_OFS  = 7'h60;
    localparam logic [6:0] DEC_RATE_OFS      = 7'h64;
    localparam logic [6:0] COMMAND_OFS       = 7'h68;
    localparam logic [6:0] ANGLE_RANGE_OFS   = 7'h6A;

    // ------------------------------------------------------------------
    // Fields, reset values and modes
    // ------------------------------------------------------------------
    localparam int         SYNC_MODE_LSB     = 2;
    localparam logic [1:0] SYNC_MODE_SCALED  = 2'h2;
    localparam int         CMD_RESET_BIT     = 0;
    localparam logic [15:0] MISC_CONTROL_RST = 16'h0000;
    localparam logic [15:0] DEC_RATE_RST     = 16'h0000;
    localparam logic [15:0] COUNT_RST        = 16'h0000;

    // ------------------------------------------------------------------
    // Timing and scale
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 100;
    localparam int STAMP_STEP_NS    = 49020;
    localparam int STAMP_STEP_CYC   = STAMP_STEP_NS / CLK_PERIOD_NS;
    localparam int NOMINAL_RATE_SPS = 2000;
    localparam logic [15:0] RANGE_DEG_0 = 16'h0168;
    localparam logic [15:0] RANGE_DEG_1 = 16'h02D0;
    localparam logic [15:0] RANGE_DEG_2 = 16'h0870;

    // ------------------------------------------------------------------
    // Sample carried in from the sensor core
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0][31:0] accel;
        logic [2:0][15:0] gyro;
        logic [15:0]      temp;
    } sample_t;

endpackage

// >>> imu_host_model.sv
// Host model that drives the register port of the output data block.
`timescale 1ns/1ns
module imu_host_model (
    input  wire logic        clk_sys,
    output logic      [6:0]  addr,
    output logic      [15:0] wrData,
    output logic             wrEn,
    output logic             rdEn,
    input  wire logic [15:0] rdData
);
    // ------------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------------
    initial begin
        addr   = 7'h00;
        wrData = 16'h0000;
        wrEn   = 1'b0;
        rdEn   = 1'b0;
    end

    // After a write the address and data lines carry the inverse, after a read only the address, so stale values never look valid.
    task automatic regWrite(input logic [6:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        addr   <= a;
        wrData <= d;
        wrEn   <= 1'b1;
        @(posedge clk_sys);
        wrEn   <= 1'b0;
        addr   <= ~a;
        wrData <= ~d;
    endtask

    task automatic regRead(input logic [6:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        addr <= a;
        rdEn <= 1'b1;
        @(posedge clk_sys);
        rdEn <= 1'b0;
        addr <= ~a;
        @(negedge clk_sys);
        d = rdData;
    endtask
endmodule // imu_host_model

// >>> imu_output_data_registers_bench.sv
// Self-checking bench for the output data register block.
`timescale 1ns/1ns
module imu_output_data_registers_bench import imu_out_pkg::*;;
    logic        clk_sys;
    logic        reset_n;
    logic        sampleValid;
    sample_t     sample;
    sample_t     s;
    logic        syncPin;
    logic [6:0]  addr;
    logic [15:0] wrData;
    logic        wrEn;
    logic        rdEn;
    logic [15:0] rdData;
    logic        dataReady;
    int          failures;
    int          nTests;

    imu_output_data_registers #(.VARIANT(0)) i_dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .sampleValid(sampleValid), .sample(sample),
        .syncPin(syncPin), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
        .rdData(rdData), .dataReady(dataReady));

    imu_host_model i_host (
        .clk_sys(clk_sys), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData));

    always #50 clk_sys = ~clk_sys;

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        nTests++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk(input logic [6:0] a, input logic [15:0] exp);
        logic [15:0] d;
        i_host.regRead(a, d);
        cmp(d, exp);
    endtask

    // Presents the same sample for n consecutive cycles.
    task automatic pulse(input sample_t v, input int n);
        @(posedge clk_sys);
        sample      <= v;
        sampleValid <= 1'b1;
        repeat (n) @(posedge clk_sys);
        sampleValid <= 1'b0;
    endtask

    // The ready pulse must stand for exactly one cycle.
    task automatic readyCheck();
        @(negedge clk_sys);
        cmp({15'h0000, dataReady}, 16'h0001);
        @(negedge clk_sys);
        cmp({15'h0000, dataReady}, 16'h0000);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic testReset();
        chk(UPD_COUNT_OFS, COUNT_RST);
        chk(7'h40, 16'h0000);
        chk(ANGLE_RANGE_OFS, RANGE_DEG_0);
        $display("test reset done");
    endtask

    task automatic testUpdate();
        s.accel[0] = 32'h7D001234;
        s.accel[1] = 32'h8300ABCD;
        s.accel[2] = 32'hFFFFFFFE;
        s.gyro[0]  = 16'h4E20;
        s.gyro[1]  = 16'hB1E0;
        s.gyro[2]  = 16'h0001;
        s.temp     = 16'hFE70;
        pulse(s, 1);
        readyCheck();
        for (int i = 0; i < 3; i++) begin
            chk(ACCEL_X_LOW_OFS + 7'(i * 4), s.accel[i][15:0]);
            chk(ACCEL_X_HIGH_OFS + 7'(i * 4), s.accel[i][31:16]);
        end
        chk(TEMP_OFS, 16'hFE70);
        chk(STAMP_OFS, 16'h0000);
        chk(UPD_COUNT_OFS, 16'h0001);
        chk(DELTA_X_LOW_OFS, 16'h4E20);
        chk(DELTA_X_HIGH_OFS, 16'h0000);
        chk(DELTA_Y_LOW_OFS, 16'hB1E0);
        chk(DELTA_Y_HIGH_OFS, 16'hFFFF);
        chk(DELTA_Z_LOW_OFS, 16'h0001);
        $display("test update done");
    endtask

    // Three samples back to back form one window; history carries over from the last update.
    task automatic testDecimation();
        i_host.regWrite(DEC_RATE_OFS, 16'h0002);
        s.gyro = '0;
        @(posedge clk_sys);
        for (int k = 1; k <= 3; k++) begin
            s.gyro[0] = 16'(k * 16);
            sample      <= s;
            sampleValid <= 1'b1;
            @(posedge clk_sys);
        end
        sampleValid <= 1'b0;
        readyCheck();
        chk(UPD_COUNT_OFS, 16'h0002);
        chk(DELTA_X_LOW_OFS, 16'h4EB0);
        chk(DELTA_Y_HIGH_OFS, 16'hFFFF);
        chk(DELTA_Y_LOW_OFS, 16'hB1E0);
        $display("test decimation done");
    endtask

    // With one-sample windows the sample beside the reset command would be an update unless it is dropped.
    task automatic testSoftReset();
        i_host.regWrite(DEC_RATE_OFS, 16'h0000);
        s.accel[0] = 32'h00005678;
        fork
            i_host.regWrite(COMMAND_OFS, 16'h0001);
            pulse(s, 1);
        join
        chk(UPD_COUNT_OFS, COUNT_RST);
        i_host.regWrite(UPD_COUNT_OFS, 16'h5555);
        chk(UPD_COUNT_OFS, COUNT_RST);
        chk(ACCEL_X_LOW_OFS, 16'h1234);
        $display("test soft reset done");
    endtask

    task automatic testWrap();
        i_host.regWrite(DEC_RATE_OFS, 16'h0000);
        pulse(s, 65535);
        chk(UPD_COUNT_OFS, 16'hFFFF);
        pulse(s, 1);
        chk(UPD_COUNT_OFS, 16'h0000);
        pulse(s, 1);
        chk(UPD_COUNT_OFS, 16'h0001);
        $display("test wrap done");
    endtask

    // The update lands about 100 cycles after the second stamp step following the sync edge.
    task automatic testStamp();
        i_host.regWrite(MISC_CONTROL_OFS, 16'(SYNC_MODE_SCALED) << SYNC_MODE_LSB);
        @(posedge clk_sys);
        syncPin <= 1'b1;
        repeat (10) @(posedge clk_sys);
        syncPin <= 1'b0;
        repeat (2 * STAMP_STEP_CYC + 93) @(posedge clk_sys);
        pulse(s, 1);
        chk(STAMP_OFS, 16'h0002);
        $display("test stamp done");
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", nTests, failures);
        if (failures == 0 && nTests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        clk_sys     = 1'b0;
        reset_n     = 1'b0;
        sampleValid = 1'b0;
        sample      = '0;
        s           = '0;
        syncPin     = 1'b0;
        failures    = 0;
        nTests      = 0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        testReset();
        testUpdate();
        testDecimation();
        testSoftReset();
        testWrap();
        testStamp();
        end_of_test();
    end
endmodule // imu_output_data_registers_bench
